//--- hw/pmw_ctrl.sv
/*
 Power mode and wake-up controller: system clock selection, NORMAL and
 SLOW switching, SLEEP0/SLEEP1/IDLE0/IDLE1 entry on halt, oscillator
 ready flags, fast wake-up on the sub clock.
 Assumes oscillator ticks are one-cycle pulses synchronous to mclk and
 that the CPU gives a one-cycle halt pulse while it still runs.
*/
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps

// Behaviour
// - Fast ready flag is zero at reset and rises once the fast oscillator settles.
// - Fast ready low in SLEEP/IDLE0; rises after 1024 crystal or 16 RC cycles.
// - Halt enters IDLE when idle select is one, otherwise SLEEP.
// - IDLE1 keeps system clock for peripherals; IDLE0 stops CPU and clock.
// - Fast select one picks undivided fast clock; zero uses divider field.
// - Switching system clock to slow clock turns the fast oscillator off.
// - Divide-by-16 and divide-by-64 ticks stop while the fast oscillator is off.
// - Fast wake-up acts only leaving SLEEP1 or IDLE0, never SLEEP0.
// - Crystal with fast wake-up runs on sub clock until 1024 cycles pass.
// - RC sources wake in 16 cycles, slow RC in 2; quick wake ignored.
// - With watchdog off no fast wake-up is given leaving SLEEP0.
// - Slow oscillator ready flag reports slow clock stability to software.
// - Halt with watchdog and monitor off enters SLEEP0, clearing and stopping watchdog.
// - Halt with watchdog or monitor on enters SLEEP1, sub clock kept running.
// - SLEEP entry keeps registers, sets power-down flag, clears expiry flag.
// - Divider 001 slow clock; 010 to 111 fast over 64,32,16,8,4,2.
// - Quick wake enable applies only to a fast crystal source.
// - Slow ready low in SLEEP0; rises after 1024 crystal or 2 RC cycles.
module pmw_ctrl (
   input  wire logic         mclk,         // system clock, 40 MHz
   input  wire logic         reset,        // synchronous, active high
   input  wire logic [1:0]   addr,         // register address
   input  wire logic [7:0]   wdata,        // write data
   input  wire logic         wr,           // write strobe
   input  wire logic         rd,           // read strobe
   output logic      [7:0]   rdata,        // read data, cycle after rd
   input  wire logic         fast_tick,    // one pulse per fast clock cycle
   input  wire logic         slow_tick,    // one pulse per slow clock cycle
   input  wire logic         halt_req,     // halt instruction pulse
   input  wire logic         wake_req,     // wake-up event
   input  wire logic         wdog_clr_req, // clear watchdog instruction
   input  wire logic         wdog_timeout, // watchdog overflow
   output pmw_pkg::pmw_clk_out_t clk_out   // clock enables and gating
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   pmw_pkg::pmw_state_t s_q;
   pmw_pkg::pmw_state_t s_d;

   function automatic logic [5:0] div_mask(input logic [2:0] code);
      logic [5:0] m;
      m = 6'h00;
      case (code)
         3'h2:    m = 6'h3F;
         3'h3:    m = 6'h1F;
         3'h4:    m = 6'h0F;
         3'h5:    m = 6'h07;
         3'h6:    m = 6'h03;
         3'h7:    m = 6'h01;
         default: m = 6'h00;
      endcase
      return m;
   endfunction : div_mask

   function automatic logic settled(input logic [10:0] cnt,
                                    input logic [10:0] lim);
      return cnt >= lim;
   endfunction : settled

   logic        fast_sel;
   logic [2:0]  div_sel;
   logic        on_slow;
   logic        fast_xtal;
   logic        slow_xtal;
   logic [10:0] fast_lim;
   logic [10:0] slow_lim;
   logic        sleeping;
   logic        run_clk;
   logic        fast_live;

   always_comb begin
      fast_sel  = s_q.ctrl[pmw_pkg::BIT_FAST_SEL];
      div_sel   = s_q.ctrl[pmw_pkg::POS_DIV_LO +: 3];
      on_slow   = !fast_sel && (div_sel <= pmw_pkg::DIV_SLOW);
      fast_xtal = s_q.cfg[pmw_pkg::CFG_FAST_XTAL];
      slow_xtal = s_q.cfg[pmw_pkg::CFG_SLOW_XTAL];
      fast_lim  = fast_xtal ? pmw_pkg::XTAL_SETTLE
                            : pmw_pkg::RC_SETTLE;
      slow_lim  = slow_xtal ? pmw_pkg::XTAL_SETTLE
                            : pmw_pkg::LRC_SETTLE;
      sleeping  = (s_q.mode != pmw_pkg::PMW_RUN);
      fast_live = s_q.fast_on && fast_tick;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d          = s_q;
      s_d.sys_tick = 1'b0;
      s_d.tick16   = 1'b0;
      s_d.tick64   = 1'b0;
      s_d.rdata    = 8'h00;
      run_clk      = 1'b0;

      // Ready counters run only while their oscillator is on.
      if (!s_q.fast_on) begin
         s_d.fast_cnt = 11'h000;
         s_d.fast_rdy = 1'b0;
      end else if (fast_tick && !settled(s_q.fast_cnt, fast_lim)) begin
         s_d.fast_cnt = s_q.fast_cnt + 11'h001;
      end else if (settled(s_q.fast_cnt, fast_lim)) begin
         s_d.fast_rdy = 1'b1;
      end
      if (s_q.mode == pmw_pkg::PMW_SLEEP0) begin
         s_d.slow_cnt = 11'h000;
         s_d.slow_rdy = 1'b0;
      end else if (slow_tick && !settled(s_q.slow_cnt, slow_lim)) begin
         s_d.slow_cnt = s_q.slow_cnt + 11'h001;
      end else if (settled(s_q.slow_cnt, slow_lim)) begin
         s_d.slow_rdy = 1'b1;
      end

      // Fast oscillator stops when the slow clock is the system clock,
      // and during SLEEP or IDLE0.
      s_d.fast_on = !on_slow && (s_q.mode == pmw_pkg::PMW_RUN ||
                                 s_q.mode == pmw_pkg::PMW_IDLE1);
      if (s_q.quick && !on_slow)
         s_d.fast_on = 1'b1;

      // Quick wake ends once the crystal has settled.
      if (s_q.quick && s_q.fast_rdy)
         s_d.quick = 1'b0;

      // Power-down mode entry and exit.
      case (s_q.mode)
         pmw_pkg::PMW_RUN: begin
            if (halt_req) begin
               s_d.pdown    = 1'b1;
               s_d.wdog_exp = 1'b0;
               if (s_q.ctrl[pmw_pkg::BIT_IDLE_SEL]) begin
                  s_d.mode = s_q.cfg[pmw_pkg::CFG_CLK_KEEP] ?
                             pmw_pkg::PMW_IDLE1 : pmw_pkg::PMW_IDLE0;
               end else if (s_q.cfg[pmw_pkg::CFG_WDOG_ON] ||
                            s_q.cfg[pmw_pkg::CFG_VMON_ON]) begin
                  s_d.mode = pmw_pkg::PMW_SLEEP1;
               end else begin
                  s_d.mode = pmw_pkg::PMW_SLEEP0;
               end
            end
         end
         pmw_pkg::PMW_SLEEP0,
         pmw_pkg::PMW_SLEEP1,
         pmw_pkg::PMW_IDLE0,
         pmw_pkg::PMW_IDLE1: begin
            if (wake_req) begin
               s_d.mode = pmw_pkg::PMW_RUN;
               // Sub clock is off only in SLEEP0 and IDLE1 keeps the fast clock,
               // so quick wake is given from SLEEP1/IDLE0 and cannot help from SLEEP0.
               s_d.quick = fast_xtal && !on_slow &&
                           s_q.ctrl[pmw_pkg::BIT_QUICK_WAKE] &&
                           (s_q.mode == pmw_pkg::PMW_SLEEP1 ||
                            s_q.mode == pmw_pkg::PMW_IDLE0);
            end
         end
         default: s_d.mode = pmw_pkg::PMW_RUN;
      endcase

      // System clock source selection.
      if (s_q.mode == pmw_pkg::PMW_RUN || s_q.mode == pmw_pkg::PMW_IDLE1) begin
         if (s_q.quick)
            run_clk = slow_tick;
         else if (!s_q.fast_rdy && !on_slow)
            run_clk = 1'b0;
         else if (fast_sel)
            run_clk = fast_live;
         else if (div_sel <= pmw_pkg::DIV_SLOW)
            // SLOW mode only clocks once the slow source has settled.
            run_clk = slow_tick && s_q.slow_rdy;
         else
            run_clk = fast_live &&
                      ((s_q.div_cnt & div_mask(div_sel)) == div_mask(div_sel));
      end
      s_d.sys_tick = run_clk;

      // Internal fast dividers halt with the fast oscillator.
      if (fast_live) begin
         s_d.div_cnt = s_q.div_cnt + 6'h01;
         s_d.tick16  = (s_q.div_cnt[3:0] == 4'hF);
         s_d.tick64  = (s_q.div_cnt == pmw_pkg::DIV_MAXCNT);
      end

      // A halt in the same cycle wins, so its power-down flag stands.
      if (wdog_clr_req && !sleeping && !halt_req) begin
         s_d.pdown    = 1'b0;
         s_d.wdog_exp = 1'b0;
      end
      if (wdog_timeout)
         s_d.wdog_exp = 1'b1;

      // Register access; ready flags are read only.
      if (wr) begin
         case (addr)
            pmw_pkg::ADDR_MODE_CTRL: begin
               s_d.ctrl = wdata;
               s_d.ctrl[pmw_pkg::BIT_FAST_RDY] = 1'b0;
               s_d.ctrl[pmw_pkg::BIT_SLOW_RDY] = 1'b0;
            end
            pmw_pkg::ADDR_SYS_CFG: s_d.cfg = wdata;
            default: ;
         endcase
      end
      if (rd) begin
         case (addr)
            pmw_pkg::ADDR_MODE_CTRL: begin
               s_d.rdata = s_q.ctrl;
               s_d.rdata[pmw_pkg::BIT_FAST_RDY] = s_q.fast_rdy;
               s_d.rdata[pmw_pkg::BIT_SLOW_RDY] = s_q.slow_rdy;
            end
            pmw_pkg::ADDR_SYS_CFG: s_d.rdata = s_q.cfg;
            pmw_pkg::ADDR_STATUS: begin
               s_d.rdata[pmw_pkg::ST_PDOWN]    = s_q.pdown;
               s_d.rdata[pmw_pkg::ST_WDOG_EXP] = s_q.wdog_exp;
               s_d.rdata[7:5]                  = s_q.mode;
            end
            default: s_d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         s_q          <= '0;
         s_q.ctrl     <= pmw_pkg::MODE_CTRL_RESET;
         s_q.cfg      <= pmw_pkg::SYS_CFG_RESET;
         s_q.mode     <= pmw_pkg::PMW_RUN;
         s_q.fast_on  <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_comb begin
      rdata               = s_q.rdata;
      clk_out.sys_tick    = s_q.sys_tick;
      clk_out.cpu_run     = (s_q.mode == pmw_pkg::PMW_RUN);
      clk_out.tick16      = s_q.tick16;
      clk_out.tick64      = s_q.tick64;
      clk_out.sub_on      = (s_q.mode != pmw_pkg::PMW_SLEEP0);
      clk_out.fast_osc_en = s_q.fast_on;
      clk_out.wdog_clear  = halt_req &&
                            (s_q.mode == pmw_pkg::PMW_RUN);
   end

endmodule : pmw_ctrl

//--- hw/pmw_pkg.sv
/*
 Package for the power mode and wake-up controller: register layout,
 reset values, mode and oscillator encodings, settle counts and the
 state record of the controller.
 Assumes a single 40 MHz mclk domain; oscillator edges arrive as
 synchronous one-cycle tick inputs.
*/
package pmw_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [1:0] ADDR_MODE_CTRL = 2'h0;
   localparam logic [1:0] ADDR_SYS_CFG   = 2'h1;
   localparam logic [1:0] ADDR_STATUS    = 2'h2;

   localparam int BIT_FAST_SEL   = 0;
   localparam int BIT_IDLE_SEL   = 1;
   localparam int BIT_FAST_RDY   = 2;
   localparam int BIT_SLOW_RDY   = 3;
   localparam int BIT_QUICK_WAKE = 4;
   localparam int POS_DIV_LO     = 5;

   localparam int CFG_CLK_KEEP   = 0;
   localparam int CFG_WDOG_ON    = 1;
   localparam int CFG_VMON_ON    = 2;
   localparam int CFG_FAST_XTAL  = 3;
   localparam int CFG_SLOW_XTAL  = 4;

   localparam int ST_PDOWN       = 0;
   localparam int ST_WDOG_EXP    = 1;

   localparam logic [7:0] MODE_CTRL_RESET = 8'h01;
   localparam logic [7:0] SYS_CFG_RESET   = 8'h02;

   // ----------------------------------------------------------------
   // Divider codes and settle counts
   // ----------------------------------------------------------------
   localparam logic [2:0] DIV_SLOW   = 3'h1;
   localparam logic [2:0] DIV_FIRST  = 3'h2;
   localparam logic [5:0] DIV_MAXCNT = 6'h3F;

   localparam logic [10:0] XTAL_SETTLE = 11'h400;
   localparam logic [10:0] RC_SETTLE   = 11'h010;
   localparam logic [10:0] LRC_SETTLE  = 11'h002;

   typedef enum logic [2:0] {
      PMW_RUN    = 3'b000,
      PMW_SLEEP0 = 3'b001,
      PMW_SLEEP1 = 3'b010,
      PMW_IDLE0  = 3'b011,
      PMW_IDLE1  = 3'b100
   } pmw_mode_t;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  cfg;
      logic        pdown;
      logic        wdog_exp;
      pmw_mode_t   mode;
      logic        fast_on;
      logic        fast_rdy;
      logic        slow_rdy;
      logic [10:0] fast_cnt;
      logic [10:0] slow_cnt;
      logic        quick;
      logic [5:0]  div_cnt;
      logic        sys_tick;
      logic        tick16;
      logic        tick64;
      logic [7:0]  rdata;
   } pmw_state_t;

   typedef struct packed {
      logic       sys_tick;
      logic       cpu_run;
      logic       tick16;
      logic       tick64;
      logic       sub_on;
      logic       fast_osc_en;
      logic       wdog_clear;
   } pmw_clk_out_t;

endpackage : pmw_pkg

//--- tb/pmw_ctrl_checker.sv
/*
 Concurrent checks on the ports of pmw_ctrl.
 Assumes one mclk domain with synchronous active-high reset.
*/
`timescale 1ns/10ps
module pmw_ctrl_checker (
   input wire logic                  mclk,     // system clock
   input wire logic                  reset,    // synchronous reset
   input wire logic                  rd,       // read strobe
   input wire logic [7:0]            rdata,    // read data
   input wire logic                  halt_req, // halt pulse
   input wire logic                  wake_req, // wake event
   input wire pmw_pkg::pmw_clk_out_t clk_out   // clock enables
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_halt;
      halt_req && clk_out.cpu_run;
   endsequence
   sequence s_parked;
      !clk_out.cpu_run && !wake_req;
   endsequence
   sequence s_osc_idle;
      !clk_out.fast_osc_en [*3];
   endsequence
   chk_halt_stops_cpu: assert property (
      s_halt |=> !clk_out.cpu_run) else $error("cpu still runs");
   chk_halt_clears_wdog: assert property (
      s_halt |-> clk_out.wdog_clear) else $error("no watchdog clear");
   chk_clear_has_cause: assert property (
      clk_out.wdog_clear |-> s_halt) else $error("stray watchdog clear");
   chk_parked_stays: assert property (
      s_parked |=> !clk_out.cpu_run) else $error("woke without event");
   chk_wake_resumes: assert property (
      !clk_out.cpu_run && wake_req |-> ##[1:2] clk_out.cpu_run)
      else $error("wake not taken");
   chk_osc_off_ticks: assert property (
      s_osc_idle |-> !clk_out.tick16 && !clk_out.tick64)
      else $error("divided tick without fast oscillator");
   chk_sleep0_no_sys: assert property (
      (!clk_out.fast_osc_en && !clk_out.cpu_run && !clk_out.sub_on) [*3]
      |-> !clk_out.sys_tick) else $error("system tick in deep sleep");
   chk_rdata_quiet: assert property (
      !$past(rd) |-> rdata == 8'h00) else $error("read data not idle");
endmodule : pmw_ctrl_checker
bind pmw_ctrl pmw_ctrl_checker u_chk (.mclk(mclk), .reset(reset), .rd(rd),
   .rdata(rdata), .halt_req(halt_req), .wake_req(wake_req),
   .clk_out(clk_out));

//--- tb/pmw_ctrl_tb.sv
/*
 Testbench for pmw_ctrl: registers, clock selection, halt and wake.
 Assumes the oscillator model: fast tick every 4, slow every 16 cycles.
*/
`timescale 1ns/10ps
module pmw_ctrl_tb;
   logic                  mclk  = 1'b0;
   logic                  reset = 1'b1;
   logic [1:0]            addr  = 2'h0;
   logic [7:0]            wdata = 8'h00;
   logic                  wr    = 1'b0;
   logic                  rd    = 1'b0;
   logic [3:0]            ev    = 4'h0; // halt, wake, clear, timeout
   logic [7:0]            rdata;
   logic                  fast_tick;
   logic                  slow_tick;
   pmw_pkg::pmw_clk_out_t clk_out;
   logic [7:0]            v;
   logic [7:0]            tbl [8][4];
   int                    error_cnt = 0;
   int                    tests_run = 0;
   int                    cyc = 0;
   int                    n_sys;
   int                    n_16;
   int                    n_64;
   always #12.5 mclk = ~mclk;
   pmw_ctrl dut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .fast_tick(fast_tick),
      .slow_tick(slow_tick), .halt_req(ev[3]), .wake_req(ev[2]),
      .wdog_clr_req(ev[1]), .wdog_timeout(ev[0]), .clk_out(clk_out));
   pmw_osc_model osc (.mclk(mclk), .reset(reset),
      .fast_en(clk_out.fast_osc_en), .sub_en(clk_out.sub_on),
      .fast_tick(fast_tick),
      .slow_tick(slow_tick));
   // ----------------------------------------------------------------
   // Access and compare tasks
   // ----------------------------------------------------------------
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a; rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   task automatic pulse(input logic [3:0] m);
      @(posedge mclk);
      ev <= m;
      @(posedge mclk);
      ev <= 4'h0;
   endtask : pulse
   task automatic count(input int n);
      n_sys = 0;
      n_16 = 0;
      n_64 = 0;
      repeat (n) begin
         @(posedge mclk);
         #1 n_sys += (clk_out.sys_tick === 1'b1);
         n_16 += (clk_out.tick16 === 1'b1);
         n_64 += (clk_out.tick64 === 1'b1);
      end
   endtask : count
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: value %h, expected %h", $time, got, exp);
      end
   endtask : cmp8
   // Tick counts may be off by one through oscillator phase.
   task automatic cmp_cnt(input int got, input int exp);
      tests_run++;
      if (exp == 0 ? got != 0 : (got < exp - 1 || got > exp + 1)) begin
         error_cnt++;
         $display("ERROR %0t: count %0d, expected %0d", $time, got, exp);
      end
   endtask : cmp_cnt
   task automatic tally_and_finish;
      $display("Checks %0d, errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      tbl = '{'{8'h01, 8'h02, 8'h41, 8'h00}, '{8'h01, 8'h00, 8'h21, 8'h00},
              '{8'h03, 8'h02, 8'h61, 8'h00}, '{8'h03, 8'h03, 8'h81, 8'h01},
              '{8'h11, 8'h0A, 8'h41, 8'h01}, '{8'h11, 8'h08, 8'h21, 8'h00},
              '{8'h01, 8'h0C, 8'h41, 8'h00}, '{8'h11, 8'h02, 8'h41, 8'h00}};
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      rd_reg(2'h0, v); cmp8(v, 8'h01);
      rd_reg(2'h1, v); cmp8(v, 8'h02);
      rd_reg(2'h2, v); cmp8(v, 8'h00);
      wr_reg(2'h3, 8'hFF);
      rd_reg(2'h3, v); cmp8(v, 8'h00);
      repeat (20) @(posedge mclk);
      rd_reg(2'h0, v); cmp8(v, 8'h01);
      repeat (100) @(posedge mclk);
      rd_reg(2'h0, v); cmp8(v, 8'h0D);
      wr_reg(2'h0, 8'h01);
      rd_reg(2'h0, v); cmp8(v, 8'h0D);
      count(512); cmp_cnt(n_sys, 128); cmp_cnt(n_16, 8);
      cmp_cnt(n_64, 2);
      for (int c = 7; c >= 0; c--) begin
         wr_reg(2'h0, {c[2:0], 5'h00});
         repeat (200) @(posedge mclk);
         count(512);
         cmp_cnt(n_sys, (c < 2) ? 32 : 128 >> (8 - c));
         if (c < 2) begin
            cmp8({7'h0, clk_out.fast_osc_en}, 8'h00);
            cmp_cnt(n_16, 0);
            cmp_cnt(n_64, 0);
         end
      end
      wr_reg(2'h0, 8'h01);
      repeat (200) @(posedge mclk);
      rd_reg(2'h0, v); cmp8(v & 8'h0C, 8'h0C);
      for (int i = 0; i < 8; i++) begin
         wr_reg(2'h0, tbl[i][0]);
         wr_reg(2'h1, tbl[i][1]);
         repeat (4300) @(posedge mclk);
         pulse(4'h1);
         rd_reg(2'h2, v); cmp8(v, 8'h02);
         pulse(4'h8);
         rd_reg(2'h2, v); cmp8(v, tbl[i][2]);
         cmp8({7'h0, clk_out.sub_on}, {7'h0, tbl[i][2] != 8'h21});
         rd_reg(2'h0, v);
         cmp8({7'h0, v[2]}, {7'h0, tbl[i][2] == 8'h81});
         if (tbl[i][2] == 8'h21) cmp8({7'h0, v[3]}, 8'h00);
         count(64);
         cmp8({7'h0, n_sys > 0}, {7'h0, tbl[i][2] == 8'h81});
         pulse(4'h4);
         count(48);
         cmp8({7'h0, n_sys > 0}, tbl[i][3]);
         rd_reg(2'h2, v); cmp8(v, 8'h01);
         pulse(4'h2);
         rd_reg(2'h2, v); cmp8(v, 8'h00);
      end
      // Slow crystal: its ready flag must lag far behind the RC figure.
      wr_reg(2'h1, 8'h10);
      wr_reg(2'h0, 8'h01);
      pulse(4'h8);
      rd_reg(2'h2, v); cmp8(v, 8'h21);
      rd_reg(2'h0, v); cmp8(v & 8'h0C, 8'h00);
      pulse(4'h4);
      repeat (200) @(posedge mclk);
      rd_reg(2'h0, v); cmp8(v & 8'h0C, 8'h04);
      // A second reset in mid-run must restore every register.
      @(posedge mclk);
      reset <= 1'b1;
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      rd_reg(2'h0, v); cmp8(v, 8'h01);
      rd_reg(2'h1, v); cmp8(v, 8'h02);
      rd_reg(2'h2, v); cmp8(v, 8'h00);
      tally_and_finish();
   end
endmodule : pmw_ctrl_tb

//--- tb/pmw_osc_model.sv
/*
 Oscillator model for the power mode controller: one-cycle ticks.
 Assumes mclk is the only clock; the fast source obeys its enable.
*/
`timescale 1ns/10ps
module pmw_osc_model #(
   parameter int FAST_DIV = 4,   // mclk cycles per fast tick
   parameter int SLOW_DIV = 16   // mclk cycles per slow tick
) (
   input  wire logic mclk,       // system clock
   input  wire logic reset,      // synchronous, active high
   input  wire logic fast_en,    // fast oscillator enable
   input  wire logic sub_en,     // sub clock enable
   output logic      fast_tick,  // fast clock pulse
   output logic      slow_tick   // slow clock pulse
);
   int fcnt_q;
   int scnt_q;
   // A disabled fast source gives no ticks at all, so gating shows.
   always_ff @(posedge mclk) begin
      fcnt_q    <= (reset || !fast_en || fcnt_q == FAST_DIV - 1) ? 0
                                                                 : fcnt_q + 1;
      fast_tick <= !reset && fast_en && fcnt_q == FAST_DIV - 1;
      scnt_q    <= (reset || !sub_en || scnt_q == SLOW_DIV - 1) ? 0
                                                                : scnt_q + 1;
      slow_tick <= !reset && sub_en && scnt_q == SLOW_DIV - 1;
   end
endmodule : pmw_osc_model
